/* File: hw/acs_pkg.sv */
package acs_pkg;

    // register map, byte addresses on the 32-bit APB
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] A_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] A_OSR = 8'h04;
    localparam logic [ADDR_W-1:0] A_GAIN = 8'h08;
    localparam logic [ADDR_W-1:0] A_SWTRIG = 8'h0C;
    localparam logic [ADDR_W-1:0] A_TRIG0 = 8'h10;
    localparam logic [ADDR_W-1:0] A_STATUS = 8'h20;
    localparam logic [ADDR_W-1:0] A_THR_HI = 8'h24;
    localparam logic [ADDR_W-1:0] A_THR_LO = 8'h28;
    localparam logic [ADDR_W-1:0] A_RES0 = 8'h30;

    // control register fields
    localparam int CTRL_W = 10;
    localparam int C_EN = 0;
    localparam int C_INCR = 1;
    localparam int C_CHOP = 2;
    localparam int C_AGC_OFF = 3;
    localparam int C_SYNC_MST = 4;
    localparam int C_SYNC_SW = 5;
    localparam int C_SYNC_TMR = 6;
    localparam int C_AUX2 = 8;
    localparam int C_AUX3 = 9;

    // trigger sources and their configuration fields
    localparam int NUM_TRIG = 4;
    localparam int TRIG_TMR = 0;
    localparam int TRIG_PIN = 1;
    localparam int TRIG_SW = 2;
    localparam int TRIG_EOC = 3;
    localparam int TRIG_W = 9;
    localparam int T_TGT_LSB = 0;
    localparam int T_MUX_LSB = 2;
    localparam int T_PRIO_LSB = 6;
    localparam int T_EN = 8;
    localparam int MUX_W = 4;

    // status register fields
    localparam int S_BUSY_LSB = 0;
    localparam int S_PEND_LSB = 2;
    localparam int S_GAIN_LSB = 8;

    // oversampling, gain and settling
    localparam int OSR_W = 10;
    localparam logic [OSR_W-1:0] OSR_RST = 10'h040;
    localparam int GAIN_W = 4;
    localparam logic [GAIN_W-1:0] MAX_GAIN_EXP = 4'h9;
    localparam logic [2:0] MOD_RST_CYCLES = 3'h4;
    localparam logic [2:0] CONT_VALID_CONV = 3'h4;
    localparam logic [2:0] INCR_VALID_CONV = 3'h3;
    localparam logic [2:0] CONV_CNT_MAX = 3'h7;

    // result channels
    localparam int NUM_CONV = 2;
    localparam int NUM_RES = 4;
    localparam int NUM_DED = 2;

endpackage

/* File: hw/acs_chan_ctrl.sv */
`timescale 1ns/1ps
module acs_chan_ctrl
    import acs_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic start,
    input wire logic stop,
    input wire logic incremental,
    input wire logic chop_en,
    input wire logic [OSR_W-1:0] oversampling_ratio,
    output logic mod_reset,
    output logic mod_run,
    output logic chop_swap,
    output logic dec_strobe,
    output logic valid,
    output logic valid_swapped,
    output logic busy
);
    typedef enum logic [1:0] {ACS_IDLE, ACS_RST, ACS_CONV} acs_chan_st_t;

    typedef struct packed {
        acs_chan_st_t st;
        logic [2:0] rst_cnt;
        logic [OSR_W-1:0] cyc;
        logic [2:0] nconv;
        logic swap;
        logic mod_reset;
        logic mod_run;
        logic dec_strobe;
        logic valid;
        logic valid_swapped;
        logic busy;
    } acs_chan_state_t;

    acs_chan_state_t s;
    acs_chan_state_t next_s;
    logic last;
    logic [2:0] nconv_inc;

    always_comb begin
        next_s = s;
        next_s.dec_strobe = 1'b0;
        next_s.valid = 1'b0;
        last = (s.cyc == oversampling_ratio - 1'b1);
        nconv_inc = (s.nconv == CONV_CNT_MAX) ? s.nconv : s.nconv + 3'h1;
        case (s.st)
            ACS_IDLE: begin
                if (start) begin
                    next_s.st = ACS_RST;
                    next_s.rst_cnt = '0;
                    next_s.mod_reset = 1'b1;
                    next_s.busy = 1'b1;
                    next_s.nconv = '0;
                    next_s.swap = 1'b0;
                end
            end
            ACS_RST: begin
                next_s.rst_cnt = s.rst_cnt + 3'h1;
                if (s.rst_cnt == MOD_RST_CYCLES - 3'h1) begin
                    next_s.st = ACS_CONV;
                    next_s.mod_reset = 1'b0;
                    next_s.mod_run = 1'b1;
                    next_s.cyc = '0;
                end
            end
            ACS_CONV: begin
                next_s.cyc = s.cyc + 1'b1;
                if (last) begin
                    next_s.cyc = '0;
                    next_s.dec_strobe = 1'b1;
                    next_s.nconv = nconv_inc;
                    if (incremental) begin
                        if (nconv_inc == INCR_VALID_CONV) begin
                            next_s.valid = 1'b1;
                            next_s.valid_swapped = s.swap;
                            if (chop_en && !s.swap) begin
                                // second pass with inputs swapped
                                next_s.swap = 1'b1;
                                next_s.st = ACS_RST;
                                next_s.rst_cnt = '0;
                                next_s.mod_reset = 1'b1;
                                next_s.mod_run = 1'b0;
                                next_s.nconv = '0;
                            end else begin
                                next_s.st = ACS_IDLE;
                                next_s.swap = 1'b0;
                                next_s.busy = 1'b0;
                                next_s.mod_run = 1'b0;
                            end
                        end
                    end else begin
                        next_s.valid = (nconv_inc >= CONT_VALID_CONV);
                        next_s.valid_swapped = 1'b0;
                        if (stop) begin
                            next_s.st = ACS_IDLE;
                            next_s.busy = 1'b0;
                            next_s.mod_run = 1'b0;
                        end
                    end
                end
            end
            default: next_s.st = ACS_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
        end else if (clk_en) begin
            s <= next_s;
        end
    end

    assign mod_reset = s.mod_reset;
    assign mod_run = s.mod_run;
    assign chop_swap = s.swap;
    assign dec_strobe = s.dec_strobe;
    assign valid = s.valid;
    assign valid_swapped = s.valid_swapped;
    assign busy = s.busy;

    // helper counters for the checks below
    logic [OSR_W:0] gap;
    logic [2:0] nstrb;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap <= '0;
            nstrb <= '0;
        end else if (clk_en) begin
            gap <= !s.mod_run ? '0 : (s.dec_strobe ? (OSR_W+1)'(1) : gap + 1'b1);
            if (s.mod_reset) begin
                nstrb <= '0;
            end else if (s.dec_strobe && nstrb != CONV_CNT_MAX) begin
                nstrb <= nstrb + 3'h1;
            end
        end
    end

    a_mod_reset_len: assert property (@(posedge pclk) disable iff (!presetn || !clk_en)
        $rose(s.mod_reset) |-> s.mod_reset [*4] ##1 !s.mod_reset)
        else $error("modulator reset not four cycles");
    a_conv_length: assert property (@(posedge pclk) disable iff (!presetn || !clk_en)
        s.dec_strobe |-> gap == {(oversampling_ratio == '0), oversampling_ratio})
        else $error("conversion length differs from oversampling ratio");
    a_cont_valid: assert property (@(posedge pclk) disable iff (!presetn || !clk_en)
        (s.valid && !incremental) |-> nstrb >= 3'h3)
        else $error("continuous result flagged before fourth conversion");
    a_incr_valid: assert property (@(posedge pclk) disable iff (!presetn || !clk_en)
        (s.valid && incremental) |-> nstrb == 3'h2)
        else $error("incremental result not after third conversion");
endmodule

/* File: hw/acs_sequencer.sv */
`timescale 1ns/1ps
module acs_sequencer
    import acs_pkg::*;
#(
    parameter int MW = 4,
    parameter int RW = 24
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic timer_trig,
    input wire logic sync_in,
    output logic sync_out,
    input wire logic [GAIN_W-1:0] agc_gain_exp,
    input wire logic [MW-1:0] mod_data0,
    input wire logic [MW-1:0] mod_data1,
    input wire logic [RW-1:0] dec_data0,
    input wire logic [RW-1:0] dec_data1,
    output logic [MUX_W-1:0] mux_sel0,
    output logic [MUX_W-1:0] mux_sel1,
    output logic [NUM_CONV-1:0] mod_reset,
    output logic [NUM_CONV-1:0] mod_run,
    output logic [NUM_CONV-1:0] chop_swap,
    output logic [NUM_CONV-1:0] dec_strobe,
    output logic [GAIN_W-1:0] gain_exp0,
    output logic [GAIN_W-1:0] gain_exp1,
    output logic [MW+int'(MAX_GAIN_EXP)-1:0] scaled0,
    output logic [MW+int'(MAX_GAIN_EXP)-1:0] scaled1,
    output logic [NUM_RES*RW-1:0] result,
    output logic [NUM_RES-1:0] res_ready,
    output logic [NUM_RES-1:0] win_cross
);
    localparam int SW = MW + int'(MAX_GAIN_EXP);

    typedef struct packed {
        logic [CTRL_W-1:0] ctrl;
        logic [OSR_W-1:0] oversampling_ratio;
        logic [GAIN_W-1:0] gain_fix;
        logic [NUM_TRIG-1:0][TRIG_W-1:0] trig;
        logic [RW-1:0] thr_hi;
        logic [RW-1:0] thr_lo;
        logic [NUM_TRIG-1:0] pend;
        logic pin_prev;
        logic sync_out;
        logic [NUM_CONV-1:0] start;
        logic [MUX_W-1:0] mux0;
        logic [MUX_W-1:0] mux1;
        logic [GAIN_W-1:0] gain0;
        logic [SW-1:0] scaled0;
        logic [SW-1:0] scaled1;
        logic [NUM_RES-1:0][RW-1:0] hold;
        logic [NUM_RES-1:0][RW-1:0] result;
        logic [NUM_RES-1:0] res_ready;
        logic [NUM_RES-1:0] win_cross;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } acs_seq_state_t;

    acs_seq_state_t s;
    acs_seq_state_t next_s;

    logic [NUM_CONV-1:0] busy;
    logic [NUM_CONV-1:0] cvalid;
    logic [NUM_CONV-1:0] cswap;
    logic [NUM_CONV-1:0] free;
    logic [NUM_TRIG-1:0] ev;
    logic [NUM_TRIG-1:0] grant_vec;
    logic [NUM_TRIG-1:0] trig_on;
    logic wr;
    logic sw_pulse;
    logic pin_lvl;
    logic found;
    logic [1:0] best_i;
    logic [1:0] best_p;
    logic [1:0] best_tgt;
    logic [MUX_W-1:0] best_mux;
    logic [1:0] tgt;
    logic chop_on;
    logic src;
    logic dsw;
    logic [RW-1:0] dd;
    logic signed [RW:0] diff;
    logic [RW-1:0] res;
    logic [31:0] rd;
    logic err;
    logic [GAIN_W-1:0] gw;

    // one controller per converter, both on pclk
    for (genvar c = 0; c < NUM_CONV; c++) begin : g_chan
        acs_chan_ctrl u_chan (
            .pclk(pclk),
            .presetn(presetn),
            .clk_en(clk_en),
            .start(s.start[c]),
            .stop(!s.ctrl[C_EN]),
            .incremental(s.ctrl[C_INCR]),
            .chop_en(s.ctrl[C_CHOP]),
            .oversampling_ratio(s.oversampling_ratio),
            .mod_reset(mod_reset[c]),
            .mod_run(mod_run[c]),
            .chop_swap(chop_swap[c]),
            .dec_strobe(dec_strobe[c]),
            .valid(cvalid[c]),
            .valid_swapped(cswap[c]),
            .busy(busy[c])
        );
    end

    always_comb begin
        next_s = s;
        next_s.start = '0;
        next_s.res_ready = '0;
        next_s.win_cross = '0;

        // register read data is prepared in the setup phase
        wr = psel && penable && s.pready && pwrite && !s.pslverr;
        sw_pulse = wr && (paddr == A_SWTRIG) && pwdata[0];
        rd = '0;
        err = 1'b0;
        if (paddr == A_CTRL) begin
            rd = 32'(s.ctrl);
        end else if (paddr == A_OSR) begin
            rd = 32'(s.oversampling_ratio);
        end else if (paddr == A_GAIN) begin
            rd = 32'(s.gain_fix);
        end else if (paddr == A_SWTRIG) begin
            rd = '0;
        end else if (paddr[7:4] == A_TRIG0[7:4] && paddr[1:0] == 2'b00) begin
            rd = 32'(s.trig[paddr[3:2]]);
        end else if (paddr == A_STATUS) begin
            rd[S_BUSY_LSB +: NUM_CONV] = busy;
            rd[S_PEND_LSB +: NUM_TRIG] = s.pend;
            rd[S_GAIN_LSB +: GAIN_W] = s.gain0;
        end else if (paddr == A_THR_HI) begin
            rd = 32'(s.thr_hi);
        end else if (paddr == A_THR_LO) begin
            rd = 32'(s.thr_lo);
        end else if (paddr[7:4] == A_RES0[7:4] && paddr[1:0] == 2'b00) begin
            rd = 32'(s.result[paddr[3:2]]);
        end else begin
            err = 1'b1;
        end
        next_s.pready = psel && !penable;
        if (psel && !penable) begin
            next_s.prdata = pwrite ? 32'h00000000 : rd;
            next_s.pslverr = err;
        end

        // fixed gain only as a power of two, 1 to 512
        gw = (pwdata[GAIN_W-1:0] > MAX_GAIN_EXP) ? MAX_GAIN_EXP : pwdata[GAIN_W-1:0];
        if (wr) begin
            if (paddr == A_CTRL) begin
                next_s.ctrl = pwdata[CTRL_W-1:0];
            end else if (paddr == A_OSR) begin
                next_s.oversampling_ratio = pwdata[OSR_W-1:0];
            end else if (paddr == A_GAIN) begin
                next_s.gain_fix = gw;
            end else if (paddr[7:4] == A_TRIG0[7:4]) begin
                next_s.trig[paddr[3:2]] = pwdata[TRIG_W-1:0];
            end else if (paddr == A_THR_HI) begin
                next_s.thr_hi = pwdata[RW-1:0];
            end else if (paddr == A_THR_LO) begin
                next_s.thr_lo = pwdata[RW-1:0];
            end
        end

        // sync pin: driven whether or not master is set; the master triggers itself from it
        next_s.sync_out = s.ctrl[C_SYNC_SW] || (s.ctrl[C_SYNC_TMR] && timer_trig);
        pin_lvl = s.ctrl[C_SYNC_MST] ? s.sync_out : sync_in;
        next_s.pin_prev = pin_lvl;
        ev[TRIG_TMR] = timer_trig;
        ev[TRIG_PIN] = pin_lvl && !s.pin_prev;
        ev[TRIG_SW] = sw_pulse;
        // end of conversion chains the next source, e.g. alternating inputs
        ev[TRIG_EOC] = |cvalid;

        // fixed priority arbitration, lower value wins, ties to lower index
        free = ~busy & ~s.start;
        found = 1'b0;
        best_i = '0;
        best_p = '1;
        best_tgt = '0;
        best_mux = '0;
        tgt = '0;
        for (int i = 0; i < NUM_TRIG; i++) begin
            trig_on[i] = s.trig[i][T_EN];
            tgt = s.trig[i][T_TGT_LSB +: NUM_CONV];
            if (s.ctrl[C_EN] && s.pend[i] && trig_on[i] && tgt != '0
                    && (tgt & free) == tgt
                    && (!found || s.trig[i][T_PRIO_LSB +: 2] < best_p)) begin
                found = 1'b1;
                best_i = 2'(i);
                best_p = s.trig[i][T_PRIO_LSB +: 2];
                best_tgt = tgt;
                best_mux = s.trig[i][T_MUX_LSB +: MUX_W];
            end
        end
        grant_vec = '0;
        if (found) begin
            grant_vec[best_i] = 1'b1;
            // one or both converters start in the same cycle
            next_s.start = best_tgt;
            // any source may go to either converter
            if (best_tgt[0]) begin
                next_s.mux0 = best_mux;
            end
            if (best_tgt[1]) begin
                next_s.mux1 = best_mux;
            end
        end
        // a new event wins over the grant that clears it
        next_s.pend = (s.pend & ~grant_vec) | (ev & trig_on);

        // gain and scaler in front of the decimator
        next_s.gain0 = s.ctrl[C_AGC_OFF] ? s.gain_fix
            : ((agc_gain_exp > MAX_GAIN_EXP) ? MAX_GAIN_EXP : agc_gain_exp);
        next_s.scaled0 = SW'($signed(mod_data0)) <<< (MAX_GAIN_EXP - s.gain0);
        next_s.scaled1 = SW'($signed(mod_data1)) <<< (MAX_GAIN_EXP - s.gain_fix);

        // result channels: two dedicated, two from either converter
        chop_on = s.ctrl[C_CHOP] && s.ctrl[C_INCR];
        src = 1'b0;
        dsw = 1'b0;
        dd = '0;
        diff = '0;
        res = '0;
        for (int r = 0; r < NUM_RES; r++) begin
            if (r < NUM_DED) begin
                src = 1'(r);
            end else begin
                src = (r == NUM_DED) ? s.ctrl[C_AUX2] : s.ctrl[C_AUX3];
            end
            dd = src ? dec_data1 : dec_data0;
            dsw = cswap[src];
            if (cvalid[src]) begin
                if (chop_on && !dsw) begin
                    next_s.hold[r] = dd;
                end else begin
                    // swapped sample negated, then averaged with the first
                    diff = $signed({s.hold[r][RW-1], s.hold[r]}) - $signed({dd[RW-1], dd});
                    res = chop_on ? diff[RW:1] : dd;
                    next_s.result[r] = res;
                    next_s.res_ready[r] = 1'b1;
                    next_s.win_cross[r] = ($signed(res) > $signed(s.thr_hi))
                        || ($signed(res) < $signed(s.thr_lo));
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
            s.oversampling_ratio <= OSR_RST;
        end else if (clk_en) begin
            s <= next_s;
        end
    end

    assign prdata = s.prdata;
    assign pready = s.pready;
    assign pslverr = s.pslverr;
    assign sync_out = s.sync_out;
    assign mux_sel0 = s.mux0;
    assign mux_sel1 = s.mux1;
    assign gain_exp0 = s.gain0;
    assign gain_exp1 = s.gain_fix;
    assign scaled0 = s.scaled0;
    assign scaled1 = s.scaled1;
    assign result = s.result;
    assign res_ready = s.res_ready;
    assign win_cross = s.win_cross;

    logic [NUM_TRIG-1:0] keep_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            keep_q <= '0;
        end else if (clk_en) begin
            keep_q <= s.pend & ~grant_vec;
        end
    end

    a_pready_setup: assert property (@(posedge pclk) disable iff (!presetn || !clk_en)
        (psel && !penable) |=> s.pready)
        else $error("pready missing after setup");
    a_start_free: assert property (@(posedge pclk) disable iff (!presetn || !clk_en)
        (found && best_tgt != '0) |-> (best_tgt & busy) == '0)
        else $error("conversion granted to busy converter");
    a_both_start: assert property (@(posedge pclk) disable iff (!presetn || !clk_en)
        (found && best_tgt == 2'b11) |=> s.start == 2'b11 ##1 busy == 2'b11)
        else $error("dual trigger did not start both together");
    a_mux_route: assert property (@(posedge pclk) disable iff (!presetn || !clk_en)
        (found && best_tgt[1]) |=> s.mux1 == $past(best_mux))
        else $error("multiplexer not routed on grant");
    a_pend_hold: assert property (@(posedge pclk) disable iff (!presetn || !clk_en)
        (s.pend & keep_q) == keep_q)
        else $error("ungranted request dropped");
    a_gain_range: assert property (@(posedge pclk) disable iff (!presetn || !clk_en)
        s.gain0 <= MAX_GAIN_EXP && s.gain_fix <= MAX_GAIN_EXP)
        else $error("gain beyond 512");
endmodule

/* File: verif/acs_afe_model.sv */
`timescale 1ns/1ps
module acs_afe_model
    import acs_pkg::*;
#(
    parameter int MW = 4,
    parameter int RW = 24
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [NUM_CONV-1:0] dec_strobe,
    output logic [MW-1:0] mod_data0,
    output logic [MW-1:0] mod_data1,
    output logic [RW-1:0] dec_data0,
    output logic [RW-1:0] dec_data1
);
    // modulator streams change every cycle; decimator words step per strobe
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mod_data0 <= '0;
            mod_data1 <= '1;
            dec_data0 <= '0;
            dec_data1 <= '0;
        end else begin
            mod_data0 <= mod_data0 + 1'b1;
            mod_data1 <= ~mod_data1;
            if (dec_strobe[0]) dec_data0 <= dec_data0 + 24'h000010;
            if (dec_strobe[1]) dec_data1 <= dec_data1 - 24'h000020;
        end
    end
endmodule

/* File: verif/tb_top.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin num_errors++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module tb_top;
    import acs_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, timer_trig, sync_out;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic e;
    logic [GAIN_W-1:0] gain_exp0, gain_exp1;
    logic [3:0] md0, md1, mux_sel0, mux_sel1, res_ready, win_cross;
    logic [23:0] dd0, dd1;
    logic [1:0] mod_reset, mod_run, chop_swap, dec_strobe;
    logic [12:0] scaled0, scaled1;
    logic [95:0] result;
    int num_errors = 0, tests_run = 0, cyc = 0, rst_len, strobes, gap, last_gap, swp;

    acs_sequencer acs_sequencer_inst (.pclk(pclk), .presetn(presetn), .clk_en(1'b1),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .timer_trig(timer_trig),
        .sync_in(1'b0), .sync_out(sync_out), .agc_gain_exp(4'h2), .mod_data0(md0),
        .mod_data1(md1), .dec_data0(dd0), .dec_data1(dd1), .mux_sel0(mux_sel0),
        .mux_sel1(mux_sel1), .mod_reset(mod_reset), .mod_run(mod_run),
        .chop_swap(chop_swap), .dec_strobe(dec_strobe), .gain_exp0(gain_exp0),
        .gain_exp1(gain_exp1), .scaled0(scaled0), .scaled1(scaled1), .result(result),
        .res_ready(res_ready), .win_cross(win_cross));
    acs_afe_model acs_afe_model_inst (.pclk(pclk), .presetn(presetn),
        .dec_strobe(dec_strobe), .mod_data0(md0), .mod_data1(md1), .dec_data0(dd0),
        .dec_data1(dd1));

    initial begin
        pclk = 0;
        forever #4 pclk = ~pclk;
    end

    // converter 0 reset width, strobe count and strobe spacing
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            complete_run();
        end
        if (mod_reset[0]) rst_len++;
        if (chop_swap[0]) swp++;
        if (dec_strobe[0]) begin
            strobes++;
            last_gap = gap;
            gap = 0;
        end else gap++;
    end

    task automatic complete_run();
        $display("errors=%0d checks=%0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wait_ready(input logic [3:0] m);
        do begin
            @(posedge pclk);
        end while ((res_ready & m) !== m);
    endtask

    task automatic regs_check();
        logic [3:0] m;
        apb(1'b0, A_OSR, 32'h0);
        `CHK(q, 32'h00000040)
        apb(1'b0, 8'h40, 32'h0);
        `CHK({e, q}, 33'h100000000)
        apb(1'b1, A_CTRL, 32'h00000028);
        apb(1'b1, A_GAIN, 32'h00000003);
        repeat (3) @(posedge pclk);
        m = md0 - 4'h1;
        `CHK(gain_exp0, 4'h3)
        `CHK(sync_out, 1'b1)
        `CHK(gain_exp1, 4'h3)
        `CHK(scaled0, {{9{m[3]}}, m} << 6)
        `CHK(scaled1, {{9{~md1[3]}}, ~md1} << 6)
        apb(1'b1, A_GAIN, 32'h0000000F);
        repeat (2) @(posedge pclk);
        `CHK(gain_exp0, MAX_GAIN_EXP)
        apb(1'b1, A_CTRL, 32'h00000000);
        repeat (2) @(posedge pclk);
        `CHK(gain_exp0, 4'h2)
    endtask

    // software trigger on converter 0, input 5, oversampling ratio 6
    task automatic one_conv(input logic [31:0] ctrl, input int exp_strobes,
            input logic [31:0] thr_lo, input logic exp_win);
        apb(1'b1, A_OSR, 32'h00000006);
        apb(1'b1, A_THR_LO, thr_lo);
        apb(1'b1, A_TRIG0 + 8'h08, 32'h00000115);
        apb(1'b1, A_CTRL, ctrl);
        rst_len = 0;
        strobes = 0;
        swp = 0;
        apb(1'b1, A_SWTRIG, 32'h00000001);
        wait_ready(4'h1);
        `CHK(mux_sel0, 4'h5)
        `CHK(rst_len, ctrl[C_CHOP] ? 8 : 4)
        `CHK(strobes, exp_strobes)
        `CHK(last_gap, 5)
        `CHK(swp, ctrl[C_CHOP] ? 22 : 0)
        `CHK(result[23:0], ctrl[C_CHOP] ? 24'hFFFFE8 : dd0 - 24'h000010)
        `CHK(win_cross[0], exp_win)
        apb(1'b1, A_CTRL, 32'h00000000);
        repeat (20) @(posedge pclk);
    endtask

    // timer trigger starting both converters on input 7
    task automatic both_conv();
        int n;
        apb(1'b1, A_TRIG0, 32'h0000011F);
        apb(1'b1, A_CTRL, 32'h00000203);
        @(posedge pclk);
        timer_trig <= 1'b1;
        @(posedge pclk);
        timer_trig <= 1'b0;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (mod_reset === 2'b00 && n < 20);
        `CHK(mod_reset, 2'b11)
        `CHK({mux_sel0, mux_sel1}, 8'h77)
        repeat (4) @(posedge pclk);
        `CHK(mod_run, 2'b11)
        wait_ready(4'h3);
        `CHK(res_ready, 4'hF)
        `CHK(result[47:24], dd1 + 24'h000020)
        `CHK(result[71:48], dd0 - 24'h000010)
        `CHK(result[95:72], dd1 + 24'h000020)
    endtask

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        timer_trig = 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        regs_check();
        one_conv(32'h00000003, 3, 32'h00000000, 1'b1);
        one_conv(32'h00000001, 4, 32'h00000000, 1'b1);
        both_conv();
        one_conv(32'h00000007, 6, 32'h00FFFFE0, 1'b0);
        complete_run();
    end
endmodule
